// *** src/bad_regs.svh ***
/*
  Constants of the binary arithmetic decoder: interval limits, byte values
  and bit counter values. Assumes inclusion by bare name from design files.
*/
`ifndef BAD_REGS_SVH
`define BAD_REGS_SVH

// -----------------------------------------------------------------------
// Interval register values
// -----------------------------------------------------------------------
`define BAD_A_INIT      16'h0000
`define BAD_A_HALF      16'h8000

// -----------------------------------------------------------------------
// Byte values and bit counter values
// -----------------------------------------------------------------------
`define BAD_STUFF_BYTE  8'hFF
`define BAD_ZERO_BYTE   8'h00
`define BAD_CT_RELOAD   4'h8
`define BAD_CT_INIT     4'h0

`endif

// *** src/bad_pkg.sv ***
/*
  Types shared by the binary arithmetic decoder files.
  Assumes nothing of its surroundings.
*/
package bad_pkg;

  // -----------------------------------------------------------------------
  // Sequencer states
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_CLR    = 3'h1,
    S_BYTE   = 3'h2,
    S_BYTEFF = 3'h3,
    S_READY  = 3'h4,
    S_DECIDE = 3'h5,
    S_RENORM = 3'h6
  } bad_state_e;

  // -----------------------------------------------------------------------
  // Where a byte fetch returns to
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    R_INIT1  = 2'h0,
    R_INIT2  = 2'h1,
    R_RENORM = 2'h2
  } bad_ret_e;

endpackage

// *** src/bad_fifo.sv ***
/*
  Byte FIFO in flip-flops with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module bad_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  logic         clk,
  input  logic         rst_n,
  // Fill side.
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  // Drain side.
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // Steps a pointer with wrap at the depth.
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // Handshakes: full and empty come straight from the fill count.
  assign in_ready  = (cnt_r != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= step(wr_r);
      end
      if (pop) begin
        rd_r <= step(rd_r);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + (AW + 1)'(1);
      end else if (pop && !push) begin
        cnt_r <= cnt_r - (AW + 1)'(1);
      end
    end
  end
endmodule // bad_fifo

// *** src/bad_est_table.sv ***
/*
  Probability estimate table in flip-flops, loaded through a write port.
  Assumes the loader fills it with the same entries the encoder uses.
*/
`timescale 1ns/1ns
module bad_est_table #(
  parameter int TW    = 7,
  parameter int DEPTH = 128
) (
  // Clock and reset.
  input  logic          clk,
  input  logic          rst_n,
  // Load port.
  input  logic          we,
  input  logic [TW-1:0] widx,
  input  logic [15:0]   wqe,
  input  logic [TW-1:0] wnmps,
  input  logic [TW-1:0] wnlps,
  input  logic          wsw,
  // Lookup port.
  input  logic [TW-1:0] ridx,
  output logic [15:0]   rqe,
  output logic [TW-1:0] rnmps,
  output logic [TW-1:0] rnlps,
  output logic          rsw
);
  logic [15:0]   qe_r   [DEPTH];
  logic [TW-1:0] nmps_r [DEPTH];
  logic [TW-1:0] nlps_r [DEPTH];
  logic [DEPTH-1:0] sw_r;

  // Lookup of one entry by index.
  assign rqe   = qe_r[ridx];
  assign rnmps = nmps_r[ridx];
  assign rnlps = nlps_r[ridx];
  assign rsw   = sw_r[ridx];

  // Entries clear at reset and take loads afterwards.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        qe_r[i]   <= '0;
        nmps_r[i] <= '0;
        nlps_r[i] <= '0;
      end
      sw_r <= '0;
    end else if (we) begin
      qe_r[widx]   <= wqe;
      nmps_r[widx] <= wnmps;
      nlps_r[widx] <= wnlps;
      sw_r[widx]   <= wsw;
    end
  end
endmodule // bad_est_table

// *** src/bad_decoder.sv ***
/*
  Adaptive binary arithmetic decoder: interval subdivision, decisions,
  renormalization, byte fetch with unstuffing, marker detection.
  Assumes a byte source holding the segment, a loaded estimate table and
  a model that pulses init_req at every restart interval.
*/
`timescale 1ns/1ns
`include "bad_regs.svh"
module bad_decoder
  import bad_pkg::*;
#(
  parameter int NCTX   = 64,
  parameter int TW     = 7,
  parameter int TDEPTH = 128,
  parameter int PW     = 32,
  parameter int FDEPTH = 32
) (
  // Clock and reset.
  input  logic                    clk,
  input  logic                    rst_n,
  // Restart control and segment position.
  input  logic                    init_req,
  input  logic [PW-1:0]           seg_start,
  output logic [PW-1:0]           segment_pointer,
  // Compressed byte source.
  input  logic                    src_valid,
  output logic                    src_ready,
  input  logic [7:0]              src_data,
  // Estimate table load.
  input  logic                    tbl_we,
  input  logic [TW-1:0]           tbl_idx,
  input  logic [15:0]             tbl_qe,
  input  logic [TW-1:0]           tbl_nmps,
  input  logic [TW-1:0]           tbl_nlps,
  input  logic                    tbl_switch,
  // Decision request and result.
  input  logic                    dec_valid,
  output logic                    dec_ready,
  input  logic [$clog2(NCTX)-1:0] dec_ctx,
  output logic                    res_valid,
  output logic                    res_bit,
  // Marker hand-off.
  output logic                    marker_valid,
  output logic [7:0]              marker_code,
  output logic                    marker_seen
);
  localparam int CW = $clog2(NCTX);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  bad_state_e       state_r;
  bad_ret_e         ret_r;
  logic [31:0]      code_r;
  logic [15:0]      a_r;
  logic [3:0]       bit_counter_r;
  logic [PW-1:0]    ptr_r;
  logic             seen_r;
  logic             mvalid_r;
  logic [7:0]       mcode_r;
  logic             rvalid_r;
  logic             rbit_r;
  logic [CW-1:0]    ctx_r;
  logic [TW-1:0]    idx_r [NCTX];
  logic [NCTX-1:0]  likely_symbol_r;

  // -----------------------------------------------------------------------
  // Byte path, table lookup and decision wires
  // -----------------------------------------------------------------------
  logic             f_valid;
  logic             f_ready;
  logic [7:0]       f_data;
  logic             byte_pop;
  logic             byte_done;
  logic             mark_hit;
  logic [7:0]       byte_val;
  logic [15:0]      minority_estimate;
  logic [TW-1:0]    t_nmps;
  logic [TW-1:0]    t_nlps;
  logic             t_sw;
  logic [15:0]      code_high_half;
  logic             cur_likely;
  logic [15:0]      a_sub;
  logic             likely_side;
  logic             exch;
  logic             renorm_need;
  logic             d_bit;
  logic             upd_likely;
  logic             upd_unlikely;
  logic [15:0]      a_dec;
  logic [15:0]      cx_dec;
  logic [15:0]      a_shift;

  // Complement of a symbol, as one minus it.
  function automatic logic flip(input logic b);
    flip = 1'(2'b01 - {1'b0, b});
  endfunction

  // Input buffering between the source and the fetch logic.
  bad_fifo #(
    .W     (8),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Shared estimate table looked up by the context's index.
  bad_est_table #(
    .TW    (TW),
    .DEPTH (TDEPTH)
  ) u_table (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (tbl_we),
    .widx  (tbl_idx),
    .wqe   (tbl_qe),
    .wnmps (tbl_nmps),
    .wnlps (tbl_nlps),
    .wsw   (tbl_switch),
    .ridx  (idx_r[ctx_r]),
    .rqe   (minority_estimate),
    .rnmps (t_nmps),
    .rnlps (t_nlps),
    .rsw   (t_sw)
  );

  // Outputs of the block.
  assign segment_pointer = ptr_r;
  assign marker_valid    = mvalid_r;
  assign marker_code     = mcode_r;
  assign marker_seen     = seen_r;
  assign res_valid       = rvalid_r;
  assign res_bit         = rbit_r;
  assign dec_ready       = (state_r == S_READY) && !init_req;

  // -----------------------------------------------------------------------
  // Byte fetch
  // -----------------------------------------------------------------------
  // Fetch pops the buffer only before a marker; afterwards zeros are fed.
  assign f_ready  = ((state_r == S_BYTE) || (state_r == S_BYTEFF)) && !seen_r;
  assign byte_pop = f_valid && f_ready;

  // Decodes what one fetch cycle delivers.
  always_comb begin
    byte_done = 1'b0;
    mark_hit  = 1'b0;
    byte_val  = `BAD_ZERO_BYTE;
    case (state_r)
      S_BYTE: begin
        if (seen_r) begin
          byte_done = 1'b1;
        end else if (byte_pop && (f_data != `BAD_STUFF_BYTE)) begin
          byte_done = 1'b1;
          byte_val  = f_data;
        end
      end
      S_BYTEFF: begin
        if (byte_pop) begin
          byte_done = 1'b1;
          if (f_data == `BAD_ZERO_BYTE) begin
            byte_val = `BAD_STUFF_BYTE;
          end else begin
            mark_hit = 1'b1;
          end
        end
      end
      default: begin
        byte_done = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------------
  // Decision arithmetic
  // -----------------------------------------------------------------------
  assign code_high_half = code_r[31:16];
  assign cur_likely     = likely_symbol_r[ctx_r];
  assign a_sub          = a_r - minority_estimate;
  assign likely_side    = code_high_half < a_sub;
  assign exch           = a_sub < minority_estimate;
  assign a_shift        = {a_r[14:0], 1'b0};

  // Picks the symbol, the new interval and code, and the update to make.
  always_comb begin
    upd_likely   = 1'b0;
    upd_unlikely = 1'b0;
    d_bit        = cur_likely;
    a_dec        = a_sub;
    cx_dec       = code_high_half;
    renorm_need  = a_sub < `BAD_A_HALF;
    if (likely_side) begin
      if (renorm_need) begin
        if (exch) begin
          d_bit        = flip(cur_likely);
          upd_unlikely = 1'b1;
        end else begin
          upd_likely = 1'b1;
        end
      end
    end else begin
      cx_dec      = code_high_half - a_sub;
      a_dec       = minority_estimate;
      renorm_need = 1'b1;
      if (exch) begin
        upd_likely = 1'b1;
      end else begin
        d_bit        = flip(cur_likely);
        upd_unlikely = 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      ret_r   <= R_INIT1;
      ctx_r   <= '0;
    end else if (init_req) begin
      state_r <= S_CLR;
    end else begin
      case (state_r)
        S_CLR: begin
          state_r <= S_BYTE;
          ret_r   <= R_INIT1;
        end
        S_BYTE, S_BYTEFF: begin
          if (byte_done) begin
            case (ret_r)
              R_INIT1: begin
                state_r <= S_BYTE;
                ret_r   <= R_INIT2;
              end
              R_INIT2:  state_r <= S_READY;
              default:  state_r <= S_RENORM;
            endcase
          end else if (byte_pop) begin
            state_r <= S_BYTEFF;
          end
        end
        S_READY: begin
          if (dec_valid) begin
            ctx_r   <= dec_ctx;
            state_r <= S_DECIDE;
          end
        end
        S_DECIDE: state_r <= renorm_need ? S_RENORM : S_READY;
        S_RENORM: begin
          if (bit_counter_r == `BAD_CT_INIT) begin
            state_r <= S_BYTE;
            ret_r   <= R_RENORM;
          end else if (a_shift[15]) begin
            state_r <= S_READY;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Interval, code register and bit counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_r        <= '0;
      a_r           <= `BAD_A_INIT;
      bit_counter_r <= `BAD_CT_INIT;
    end else if (!init_req) begin
      if (state_r == S_CLR) begin
        code_r <= '0;
        a_r    <= `BAD_A_INIT;
      end else if (byte_done) begin
        if (ret_r == R_RENORM) begin
          code_r[15:8]  <= byte_val;
          bit_counter_r <= `BAD_CT_RELOAD;
        end else begin
          code_r <= {code_r[23:16], byte_val, 16'h0000};
          if (ret_r == R_INIT2) begin
            bit_counter_r <= `BAD_CT_INIT;
          end
        end
      end else if (state_r == S_DECIDE) begin
        a_r           <= a_dec;
        code_r[31:16] <= cx_dec;
      end else if ((state_r == S_RENORM) && (bit_counter_r != `BAD_CT_INIT)) begin
        a_r           <= a_shift;
        code_r        <= {code_r[30:0], 1'b0};
        bit_counter_r <= bit_counter_r - 4'h1;
      end
    end
  end

  // Segment pointer and marker hand-off.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_r    <= '0;
      seen_r   <= 1'b0;
      mvalid_r <= 1'b0;
      mcode_r  <= `BAD_ZERO_BYTE;
    end else begin
      mvalid_r <= 1'b0;
      if (init_req) begin
        seen_r <= 1'b0;
      end else if (state_r == S_CLR) begin
        ptr_r <= seg_start - PW'(1);
      end else if (mark_hit) begin
        ptr_r    <= ptr_r - PW'(1);
        seen_r   <= 1'b1;
        mvalid_r <= 1'b1;
        mcode_r  <= f_data;
      end else if (byte_pop) begin
        ptr_r <= ptr_r + PW'(1);
      end
    end
  end

  // Per-context store: cleared at initialization, adapted after decisions.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      likely_symbol_r <= '0;
      for (int i = 0; i < NCTX; i++) begin
        idx_r[i] <= '0;
      end
    end else if (!init_req) begin
      if (state_r == S_CLR) begin
        likely_symbol_r <= '0;
        for (int i = 0; i < NCTX; i++) begin
          idx_r[i] <= '0;
        end
      end else if ((state_r == S_DECIDE) && upd_likely) begin
        idx_r[ctx_r] <= t_nmps;
      end else if ((state_r == S_DECIDE) && upd_unlikely) begin
        idx_r[ctx_r] <= t_nlps;
        if (t_sw) begin
          likely_symbol_r[ctx_r] <= flip(cur_likely);
        end
      end
    end
  end

  // Result bit and its one-cycle strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rbit_r   <= 1'b0;
    end else begin
      rvalid_r <= 1'b0;
      if (!init_req) begin
        if (state_r == S_DECIDE) begin
          rbit_r   <= d_bit;
          rvalid_r <= !renorm_need;
        end else if ((state_r == S_RENORM) && (bit_counter_r != `BAD_CT_INIT)) begin
          rvalid_r <= a_shift[15];
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  property p_shift_carry;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && state_r == S_RENORM && bit_counter_r != 4'h0)
      |=> code_r[16] == $past(code_r[15]) && code_r[0] == 1'b0;
  endproperty
  a_shift_carry: assert property (p_shift_carry)
    else $error("code shift lost bit 15");

  property p_norm_result;
    @(posedge clk) disable iff (!rst_n) rvalid_r |-> a_r[15];
  endproperty
  a_norm_result: assert property (p_norm_result)
    else $error("result given with interval below half");

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && byte_done && ret_r == R_RENORM)
      |=> bit_counter_r == 4'h8 ##1 (init_req || state_r != S_RENORM || bit_counter_r == 4'h7);
  endproperty
  a_reload: assert property (p_reload)
    else $error("bit counter not reloaded to eight");

  property p_ptr_step;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && byte_pop && !mark_hit && state_r != S_CLR)
      |=> ptr_r == $past(ptr_r) + PW'(1);
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("segment pointer did not advance");

  property p_plain_byte;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && state_r == S_BYTE && byte_pop && f_data != 8'hFF
       && ret_r == R_RENORM) |=> code_r[15:8] == $past(f_data);
  endproperty
  a_plain_byte: assert property (p_plain_byte)
    else $error("byte not placed in low half");

  property p_unstuff;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && state_r == S_BYTEFF && byte_pop && f_data == 8'h00
       && ret_r == R_RENORM) |=> code_r[15:8] == 8'hFF && !seen_r;
  endproperty
  a_unstuff: assert property (p_unstuff)
    else $error("stuffed zero not removed");

  property p_marker;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && mark_hit) |=> mvalid_r && seen_r && mcode_r == $past(f_data)
      && ptr_r == $past(ptr_r) - PW'(1) ##1 !mvalid_r;
  endproperty
  a_marker: assert property (p_marker)
    else $error("marker not handed on");

  property p_zero_feed;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && seen_r && state_r == S_BYTE && ret_r == R_RENORM)
      |-> !f_ready ##1 (code_r[15:8] == 8'h00 && $stable(ptr_r));
  endproperty
  a_zero_feed: assert property (p_zero_feed)
    else $error("zero feed after marker broken");

  property p_init;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && state_r == S_CLR) |=> (ptr_r + PW'(1) == $past(seg_start))
      && a_r == 16'h0000 && likely_symbol_r == '0 && state_r == S_BYTE;
  endproperty
  a_init: assert property (p_init)
    else $error("initialization values wrong");

  property p_lps_interval;
    @(posedge clk) disable iff (!rst_n)
      (!init_req && state_r == S_DECIDE && !likely_side)
      |=> a_r == $past(minority_estimate) && state_r == S_RENORM;
  endproperty
  a_lps_interval: assert property (p_lps_interval)
    else $error("unlikely path interval wrong");
endmodule // bad_decoder

// *** tb/bad_src_model.sv ***
/*
  Byte source model that offers the compressed segment to the decoder.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module bad_src_model (
  // Clock and reset.
  input  logic       clk,
  input  logic       rst_n,
  // Byte stream.
  output logic       src_valid,
  input  logic       src_ready,
  output logic [7:0] src_data
);
  logic [7:0] seg [10] = '{8'hFF, 8'h00, 8'hF0, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF,
                           8'hD0};
  int         pos;
  // Bytes go out in segment order with a gap cycle; idle data is inverted.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_valid <= 1'b0;
      src_data  <= 8'h00;
      pos       <= 0;
    end else if (src_valid && src_ready) begin
      src_valid <= 1'b0;
      src_data  <= ~src_data;
      pos       <= pos + 1;
    end else if (!src_valid && pos < 10) begin
      src_valid <= 1'b1;
      src_data  <= seg[pos];
    end
  end
endmodule // bad_src_model

// *** tb/bad_decoder_test.sv ***
/*
  Self-checking bench for the decoder with a byte source model.
  Assumes the design sources and package are compiled first.
*/
`timescale 1ns/1ns
module bad_decoder_test;
  logic        clk, rst_n, init_req, src_valid, src_ready, tbl_we, tbl_switch;
  logic        dec_valid, dec_ready, res_valid, res_bit, marker_valid, marker_seen;
  logic [7:0]  src_data, marker_code;
  logic [15:0] tbl_qe;
  logic [6:0]  tbl_idx, tbl_nlps;
  logic [5:0]  dec_ctx;
  logic [31:0] segment_pointer;
  logic        b;
  int          lat, err_total, checked, marks;

  // Design and byte source.
  bad_decoder bad_decoder_i (.clk(clk), .rst_n(rst_n), .init_req(init_req),
    .seg_start(32'h0000_0100), .segment_pointer(segment_pointer), .src_valid(src_valid),
    .src_ready(src_ready), .src_data(src_data), .tbl_we(tbl_we), .tbl_idx(tbl_idx),
    .tbl_qe(tbl_qe), .tbl_nmps(7'h00), .tbl_nlps(tbl_nlps), .tbl_switch(tbl_switch),
    .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_ctx(dec_ctx), .res_valid(res_valid),
    .res_bit(res_bit), .marker_valid(marker_valid), .marker_code(marker_code),
    .marker_seen(marker_seen));
  bad_src_model bad_src_model_i (.clk(clk), .rst_n(rst_n), .src_valid(src_valid),
    .src_ready(src_ready), .src_data(src_data));

  // Clock of 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counts marker strobes, sampled mid-cycle where they are settled.
  always @(negedge clk) begin
    if (marker_valid === 1'b1) begin
      marks++;
    end
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Loads estimate entry 0, restarts and waits for the decoder to be ready.
  task automatic restart(input logic [15:0] qe, input logic sw, input logic [6:0] nlps);
    @(posedge clk);
    tbl_we     <= 1'b1;
    tbl_idx    <= 7'h00;
    tbl_qe     <= qe;
    tbl_nlps   <= nlps;
    tbl_switch <= sw;
    init_req   <= 1'b1;
    @(posedge clk);
    tbl_we   <= 1'b0;
    init_req <= 1'b0;
    lat = 0;
    do begin @(posedge clk); #1; lat++; end while (dec_ready !== 1'b1 && lat < 200);
    check(dec_ready, 1'b1);
  endtask

  // Issues one decision and waits for its result pulse.
  task automatic decide(input logic [5:0] ctx);
    @(posedge clk);
    dec_valid <= 1'b1;
    dec_ctx   <= ctx;
    @(posedge clk);
    dec_valid <= 1'b0;
    lat = 0;
    do begin @(posedge clk); #1; lat++; end while (res_valid !== 1'b1 && lat < 100);
    check(res_valid, 1'b1);
    b = res_bit;
  endtask

  // Stuffed pair, then a less likely symbol that switches sense and moves the
  // context to entry 1, whose estimate then decides the next symbol.
  task automatic t_lps();
    @(posedge clk);
    tbl_we  <= 1'b1;
    tbl_idx <= 7'h01;
    tbl_qe  <= 16'h7000;
    restart(16'h4000, 1'b1, 7'h01);
    check(segment_pointer, 32'h0000_0102);
    decide(6'h00);
    check(b, 1'b1);
    check(segment_pointer, 32'h0000_0103);
    decide(6'h00);
    check(b, 1'b1);
  endtask

  // Plain likely symbol, then an exchanged decision whose renormalization
  // fetches a stuffed pair, after a fresh init.
  task automatic t_swap();
    restart(16'h6000, 1'b0, 7'h00);
    check(marker_seen, 1'b0);
    decide(6'h00);
    check(b, 1'b0);
    check(lat, 1);
    decide(6'h00);
    check(b, 1'b1);
    check(segment_pointer, 32'h0000_0103);
  endtask

  // Marker at the segment start: reported, pointer wound back, zeros fed.
  task automatic t_marker();
    restart(16'h6000, 1'b0, 7'h00);
    check(marker_seen, 1'b1);
    check(marker_code, 8'hD0);
    check(marks, 1);
    check(segment_pointer, 32'h0000_00FF);
    decide(6'h00);
    check(b, 1'b0);
    decide(6'h00);
    check(b, 1'b1);
    check(segment_pointer, 32'h0000_00FF);
  endtask

  // Main sequence after four reset cycles.
  initial begin
    err_total = 0;
    checked   = 0;
    rst_n      = 1'b0;
    init_req   = 1'b0;
    tbl_we     = 1'b0;
    tbl_qe     = 16'h0000;
    tbl_idx    = 7'h00;
    tbl_nlps   = 7'h00;
    tbl_switch = 1'b0;
    dec_valid  = 1'b0;
    dec_ctx    = 6'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_lps();
    t_swap();
    t_marker();
    report_and_stop();
  end

  // Watchdog against a hang.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule // bad_decoder_test
